/* odrb_register_bank.sv */
/*
 Register bank of an eight-channel voltage-output converter.
 Assumes the serial front end supplies a one-cycle write strobe at the
 end of the acknowledge after the lower data byte, plus selector and
 data synchronous to clk; reads are combinational on the selector.
*/
// Summary of operation
// - Selector 01h is configuration, resets 00FFh.
// - Selector 02h holds identifier; writes take reset key.
// - Selector 03h is broadcast code register.
// - Selectors 08h-0Fh are channel codes, reset zero.
// - Codes sit in bits 11..2, MSB aligned.
// - Global power-down overrides all channel bits.
// - Bits 7..0 power down channels H..A.
// - Channels start powered down after reset.
// - Key 1010 in low nibble resets all.
// - Broadcast write updates every channel code.
// - Writes commit on the acknowledge-end strobe.
`timescale 1ns/1ps
`include "odrb_map.svh"
module odrb_register_bank
   import odrb_pkg::*;
#(
   parameter int          CODE_W   = 10,
   parameter int          CHANNELS = 8,
   parameter logic [5:0]  PART_ID  = 6'h2A  // Arbitrary value
)
(
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // Register access from the serial front end
   input  wire logic                    wrCommit,
   input  wire odrb_pkg::odrb_sel_t     regSel,
   input  wire odrb_pkg::odrb_word_t    wrData,
   output odrb_pkg::odrb_word_t         rdData,
   output logic                         rdValid,
   // Analog controls
   output logic                         globalPowerDown,
   output logic [CHANNELS-1:0]          channelPowerDown,
   output logic [CHANNELS*CODE_W-1:0]   activeCodes
);
   import odrb_pkg::*;

   // Decode and field layout serve eight channels of 8 or 10 bits only
   if (CHANNELS != 8 || (CODE_W != 10 && CODE_W != 8))
   begin : gBadParams
      $error("odrb_register_bank: unsupported parameters");
   end

   odrb_word_t configReg;
   odrb_word_t allCode;
   odrb_word_t chanWord [CHANNELS];

   wire logic hitConfig  = regSel == `ODRB_SEL_CONFIG;
   wire logic hitIdent   = regSel == `ODRB_SEL_IDENT;
   wire logic hitAllCode = regSel == `ODRB_SEL_ALLCODE;
   wire logic hitChan    = regSel >= `ODRB_SEL_CHAN_BASE &&
                           regSel <= `ODRB_SEL_CHAN_LAST;
   wire logic [2:0] chanIdx = regSel[2:0];

   wire logic wrConfig  = wrCommit & hitConfig;
   wire logic wrAllCode = wrCommit & hitAllCode;
   wire logic softReset = wrCommit & hitIdent &
      (wrData[`ODRB_KEY_HI:`ODRB_KEY_LO] == `ODRB_RESET_KEY);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         configReg <= `ODRB_CONFIG_RESET;
      else if (softReset)
         configReg <= `ODRB_CONFIG_RESET;
      else if (wrConfig)
         configReg <= {7'h00, wrData[`ODRB_GPD_BIT:0]};
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         allCode <= `ODRB_CODE_RESET;
      else if (softReset)
         allCode <= `ODRB_CODE_RESET;
      else if (wrAllCode)
         allCode <= {4'h0, wrData[`ODRB_CODE_HI:`ODRB_CODE_LO], 2'h0};
   end

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : gChan
         odrb_channel_code #(.CODE_W(CODE_W)) uCode (
            .clk        (clk),
            .rst_n      (rst_n),
            .softReset  (softReset),
            .loadOwn    (wrCommit & hitChan & (chanIdx == 3'(g))),
            .loadAll    (wrAllCode),
            .wrData     (wrData),
            .codeWord   (chanWord[g]),
            .activeCode (activeCodes[g*CODE_W +: CODE_W])
         );
      end
   endgenerate

   assign globalPowerDown  = configReg[`ODRB_GPD_BIT];
   assign channelPowerDown = configReg[`ODRB_PD_HI:0] |
                             {CHANNELS{configReg[`ODRB_GPD_BIT]}};

   // Key nibble is write-only and reads as zero
   wire odrb_word_t identWord =
      {4'h0, PART_ID, 6'h00};

   assign rdValid = hitConfig | hitIdent | hitAllCode | hitChan;
   assign rdData  = hitConfig  ? configReg :
                    hitIdent   ? identWord :
                    hitAllCode ? allCode :
                    hitChan    ? chanWord[chanIdx] : 16'h0000;

   // Checks
   property p_reset_value;
      @(posedge clk) disable iff (!rst_n)
      softReset |=> configReg == `ODRB_CONFIG_RESET && allCode == 16'h0000;
   endproperty
   a_reset_value: assert property (p_reset_value)
      else $error("soft reset did not restore defaults");

   property p_config_write;
      @(posedge clk) disable iff (!rst_n)
      wrConfig |=> configReg == {7'h00, $past(wrData[8:0])};
   endproperty
   a_config_write: assert property (p_config_write)
      else $error("configuration write wrong");

   property p_global_pd;
      @(posedge clk) disable iff (!rst_n)
      globalPowerDown |-> &channelPowerDown;
   endproperty
   a_global_pd: assert property (p_global_pd)
      else $error("global power-down not applied");

   property p_broadcast;
      @(posedge clk) disable iff (!rst_n)
      wrAllCode && !softReset |=> chanWord[0] == allCode &&
                                  chanWord[7] == allCode;
   endproperty
   a_broadcast: assert property (p_broadcast)
      else $error("broadcast did not reach channels");

   property p_chan_write;
      @(posedge clk) disable iff (!rst_n)
      wrCommit && hitChan && chanIdx == 3'h3 |=>
         chanWord[3][11:2] == $past(wrData[11:2]);
   endproperty
   a_chan_write: assert property (p_chan_write)
      else $error("channel D write lost");

   property p_no_commit_hold;
      @(posedge clk) disable iff (!rst_n)
      !wrCommit |=> $stable(configReg) && $stable(allCode);
   endproperty
   a_no_commit_hold: assert property (p_no_commit_hold)
      else $error("register changed without commit");

   property p_field_clean;
      @(posedge clk) disable iff (!rst_n)
      allCode[15:12] == 4'h0 && allCode[1:0] == 2'h0;
   endproperty
   a_field_clean: assert property (p_field_clean)
      else $error("code outside field");

   property p_ident_read;
      @(posedge clk) disable iff (!rst_n)
      hitIdent |-> rdData[3:0] == 4'h0 && rdData[11:6] == PART_ID;
   endproperty
   a_ident_read: assert property (p_ident_read)
      else $error("identity read wrong");

   property p_unmapped;
      @(posedge clk) disable iff (!rst_n)
      wrCommit && !rdValid |=> $stable(configReg) && $stable(allCode);
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped write changed state");

   c_soft_reset: cover property (@(posedge clk) disable iff (!rst_n)
      softReset);
   c_broadcast: cover property (@(posedge clk) disable iff (!rst_n)
      wrAllCode);
   c_power_up: cover property (@(posedge clk) disable iff (!rst_n)
      wrConfig ##1 channelPowerDown == 8'h00);
endmodule : odrb_register_bank

/* odrb_map.svh */
/*
 Register bank constants: selectors, field positions, reset values.
 Assumes inclusion by the register bank and channel code modules.
*/
`ifndef ODRB_MAP_SVH
`define ODRB_MAP_SVH
`define ODRB_SEL_CONFIG      8'h01
`define ODRB_SEL_IDENT       8'h02
`define ODRB_SEL_ALLCODE     8'h03
`define ODRB_SEL_CHAN_BASE   8'h08
`define ODRB_SEL_CHAN_LAST   8'h0F
`define ODRB_CONFIG_RESET    16'h00FF
`define ODRB_CODE_RESET      16'h0000
`define ODRB_GPD_BIT         8
`define ODRB_PD_HI           7
`define ODRB_CODE_HI         11
`define ODRB_CODE_LO         2
`define ODRB_ID_HI           11
`define ODRB_ID_LO           6
`define ODRB_KEY_HI          3
`define ODRB_KEY_LO          0
`define ODRB_RESET_KEY       4'hA
`endif

/* odrb_pkg.sv */
/*
 Types shared by the register bank modules.
 Assumes odrb_map.svh is on the include path.
*/
package odrb_pkg;
   typedef logic [15:0] odrb_word_t;
   typedef logic [7:0]  odrb_sel_t;
   typedef enum logic [0:0] {ODRB_RES10, ODRB_RES8} odrb_res_e;
endpackage : odrb_pkg

/* odrb_channel_code.sv */
/*
 One channel code register with its active code output.
 Assumes load strobes are one-cycle pulses from the bank decoder.
*/
`timescale 1ns/1ps
`include "odrb_map.svh"
module odrb_channel_code
   import odrb_pkg::*;
#(
   parameter int CODE_W = 10
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Control
   input  wire logic              softReset,
   input  wire logic              loadOwn,
   input  wire logic              loadAll,
   input  wire odrb_pkg::odrb_word_t wrData,
   // State
   output odrb_pkg::odrb_word_t   codeWord,
   output logic [CODE_W-1:0]      activeCode
);
   // The code field cannot hold more bits than its documented span
   if (CODE_W < 1 || CODE_W > `ODRB_CODE_HI - `ODRB_CODE_LO + 1)
   begin : gBadWidth
      $error("odrb_channel_code: unsupported CODE_W");
   end

   wire logic loadAny = loadOwn | loadAll;
   wire odrb_word_t maskedWord =
      {4'h0, wrData[`ODRB_CODE_HI:`ODRB_CODE_LO], 2'h0};

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         codeWord <= `ODRB_CODE_RESET;
      else if (softReset)
         codeWord <= `ODRB_CODE_RESET;
      else if (loadAny)
         codeWord <= maskedWord;
   end

   // Low field bits are ignored by the 8-bit variant
   assign activeCode = codeWord[`ODRB_CODE_HI -: CODE_W];
endmodule : odrb_channel_code

/* odrb_host_model.sv */
/*
 Bus controller model: issues committed register writes, points reads.
 Assumes the bench clock; outputs change only on falling edges.
*/
`timescale 1ns/1ps
module odrb_host_model
(
   // Clock
   input  wire logic            clk,
   // Register access
   output logic                 wrCommit,
   output odrb_pkg::odrb_sel_t  regSel,
   output odrb_pkg::odrb_word_t wrData
);
   import odrb_pkg::*;
   initial
   begin
      wrCommit = 1'b0;
      regSel   = 8'h00;
      wrData   = 16'h0000;
   end
   task writeReg(input odrb_sel_t sel, input odrb_word_t data);
      @(negedge clk);
      regSel   = sel;
      wrData   = data;
      wrCommit = 1'b1;
      @(negedge clk);
      wrCommit = 1'b0;
      // Released lines show the inverse so stale data never looks valid
      wrData   = ~data;
   endtask : writeReg
   task pointSel(input odrb_sel_t sel);
      @(negedge clk);
      regSel = sel;
   endtask : pointSel
endmodule : odrb_host_model

/* octal_dac_register_bank_tb.sv */
/*
 Self-checking bench for the register bank with a host model.
 Assumes default CODE_W of 10 and eight channels.
*/
`timescale 1ns/1ps
module octal_dac_register_bank_tb;
   import odrb_pkg::*;
   localparam logic [5:0] PartId = 6'h15;  // Arbitrary value
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       wrCommit;
   odrb_sel_t  regSel;
   odrb_word_t wrData;
   odrb_word_t rdData;
   logic       rdValid;
   logic       globalPowerDown;
   logic [7:0] channelPowerDown;
   logic [79:0] activeCodes;
   int         nErrors = 0;
   int         comparisons = 0;
   always #2.5 clk = ~clk;
   odrb_register_bank #(.PART_ID(PartId)) u_odrb_register_bank (
      .clk(clk), .rst_n(rst_n), .wrCommit(wrCommit), .regSel(regSel),
      .wrData(wrData), .rdData(rdData), .rdValid(rdValid),
      .globalPowerDown(globalPowerDown),
      .channelPowerDown(channelPowerDown), .activeCodes(activeCodes));
   odrb_host_model u_odrb_host_model (
      .clk(clk), .wrCommit(wrCommit), .regSel(regSel), .wrData(wrData));
   task check(input odrb_word_t got, input odrb_word_t exp, input string m);
      comparisons++;
      if (got !== exp)
      begin
         nErrors++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : check
   task readReg(input odrb_sel_t sel, input odrb_word_t exp, input string m);
      u_odrb_host_model.pointSel(sel);
      #1;
      check(rdData, exp, m);
      check({15'h0, rdValid}, 16'h0001, "mapped valid");
   endtask : readReg
   task checkCodes(input logic [9:0] exp);
      for (int n = 0; n < 8; n++)
         check({6'h00, activeCodes[n*10 +: 10]}, {6'h00, exp}, "code");
   endtask : checkCodes
   task resetValues;
      readReg(8'h01, 16'h00FF, "config reset");
      check({7'h00, globalPowerDown, channelPowerDown}, 16'h00FF, "pd");
      readReg(8'h02, {4'h0, PartId, 6'h00}, "identifier");
      for (int n = 0; n < 8; n++)
         readReg(8'h08 + n, 16'h0000, "code reset");
      checkCodes(10'h000);
   endtask : resetValues
   task channelCodes;
      for (int n = 0; n < 8; n++)
         u_odrb_host_model.writeReg(8'h08 + n, 16'hF003 | ((n*37+1) << 2));
      for (int i = 4; i < 8; i++)
         u_odrb_host_model.writeReg(8'(i), 16'hFFFF);
      u_odrb_host_model.writeReg(8'h00, 16'hFFFF);
      u_odrb_host_model.writeReg(8'h10, 16'hFFFF);
      readReg(8'h01, 16'h00FF, "unmapped config");
      readReg(8'h03, 16'h0000, "unmapped broadcast");
      for (int n = 0; n < 8; n++)
      begin
         readReg(8'h08 + n, 16'((n*37+1) << 2), "channel read");
         check({6'h00, activeCodes[n*10 +: 10]}, 16'(n*37+1), "act");
      end
      u_odrb_host_model.pointSel(8'h05);
      #1;
      check({15'h0, rdValid}, 16'h0000, "unmapped valid");
      check(rdData, 16'h0000, "unmapped data");
   endtask : channelCodes
   task powerControl;
      u_odrb_host_model.writeReg(8'h01, 16'hFE5A);
      readReg(8'h01, 16'h005A, "config bits");
      check({8'h00, channelPowerDown}, 16'h005A, "channel pd");
      u_odrb_host_model.writeReg(8'h01, 16'h0000);
      check({8'h00, channelPowerDown}, 16'h0000, "on");
      check({15'h0, globalPowerDown}, 16'h0000, "gpd off");
      u_odrb_host_model.writeReg(8'h01, 16'h0100);
      readReg(8'h01, 16'h0100, "global bit");
      check({7'h00, globalPowerDown, channelPowerDown}, 16'h01FF, "gpd");
   endtask : powerControl
   task broadcast;
      u_odrb_host_model.writeReg(8'h03, 16'h1234);
      readReg(8'h03, 16'h0234, "broadcast reg");
      checkCodes(10'h08D);
   endtask : broadcast
   task softReset;
      u_odrb_host_model.writeReg(8'h02, 16'h0005);
      readReg(8'h01, 16'h0100, "no key");
      u_odrb_host_model.writeReg(8'h02, 16'hFFFA);
      readReg(8'h01, 16'h00FF, "key config");
      readReg(8'h03, 16'h0000, "key broadcast");
      checkCodes(10'h000);
   endtask : softReset
   task completeRun;
      $display("errors %0d comparisons %0d", nErrors, comparisons);
      if (nErrors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : completeRun
   initial
   begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      resetValues();
      channelCodes();
      powerControl();
      broadcast();
      softReset();
      completeRun();
   end
   // About 72 cycles are needed; allow a wide margin
   initial
   begin
      #5000;
      nErrors++;
      completeRun();
   end
endmodule : octal_dac_register_bank_tb
